// file: tdhc_pkg.sv
// package with register map, field positions, codes and carrier types for the tx hdlc controller
package tdhc_pkg;
	localparam logic [13:0] TDHC_IDX_CTRL = 14'h0113;
	localparam logic [13:0] TDHC_IDX_COUNT = 14'h0114;
	localparam logic [13:0] TDHC_IDX_IRQ_STAT = 14'h0115;
	localparam logic [13:0] TDHC_IDX_IRQ_MASK = 14'h0116;
	localparam logic [5:0] TDHC_IDX_BUF0_PAGE = 6'h06;
	localparam logic [5:0] TDHC_IDX_BUF1_PAGE = 6'h07;
	localparam int TDHC_CTRL_MOS_BIT = 0;
	localparam int TDHC_CTRL_FCS_BIT = 1;
	localparam int TDHC_CNT_SEL_BIT = 7;
	localparam int TDHC_IRQ_EOT_BIT = 0;
	localparam logic [6:0] TDHC_COUNT_RESET = 7'h00;
	localparam logic [7:0] TDHC_FLAG = 8'h7e;
	localparam logic [15:0] TDHC_CRC_INIT = 16'hffff;
	localparam logic [15:0] TDHC_CRC_POLY = 16'h8408;
	localparam logic [2:0] TDHC_STUFF_RUN = 3'd5;
	localparam int TDHC_MEM_WORDS = 256;

	typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_FCS, TX_BOS} tdhc_tx_e;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [15:0] paddr;
		logic [31:0] pwdata;
	} tdhc_apb_req_s;

	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} tdhc_apb_rsp_s;

	typedef struct packed {
		logic [15:0] crc;
	} tdhc_crc_s;

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic slverr;
		logic fcs_en;
		logic message_oriented_signaling;
		logic sel;
		logic [6:0] count;
		logic [1:0] busy;
		logic pend;
		logic cur_buf;
		logic cur_mos;
		logic cur_fcs;
		logic [6:0] cur_len;
		logic [6:0] idx;
		logic [6:0] reps;
		tdhc_tx_e tx;
		logic [7:0] sh;
		logic [2:0] bitcnt;
		logic [2:0] ones;
		logic stuff;
		logic dl_bit;
		logic irq_stat;
		logic irq_mask;
	} tdhc_state_s;
endpackage : tdhc_pkg

// file: tdhc_crc16.sv
// bit-serial crc16 for the frame check sequence, lsb first
`timescale 1ns/1ps
module tdhc_crc16 (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic init,
	input wire logic en,
	input wire logic din,
	output tdhc_pkg::tdhc_crc_s crc_q,
	output tdhc_pkg::tdhc_crc_s crc_next
);
	import tdhc_pkg::*;
	tdhc_crc_s st;
	tdhc_crc_s next_st;

	always_comb
	begin
		next_st = st;
		if (init)
			next_st.crc = TDHC_CRC_INIT;
		else if (en)
			next_st.crc = (st.crc >> 1) ^ ((st.crc[0] ^ din) ? TDHC_CRC_POLY : 16'h0000);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st <= '{crc: TDHC_CRC_INIT};
		else
			st <= next_st;
	end

	assign crc_q = st;
	assign crc_next = next_st;
endmodule : tdhc_crc16

// file: tdhc_top.sv
// tx data-link hdlc controller: apb registers, two message buffers, bit serializer
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module tdhc_top (
	input wire logic pclk,
	input wire logic presetn,
	input tdhc_pkg::tdhc_apb_req_s apb_req,
	output tdhc_pkg::tdhc_apb_rsp_s apb_rsp,
	input wire logic dl_bit_req,
	output logic dl_bit,
	output logic tx_end_of_transfer_irq
);
	import tdhc_pkg::*;
	tdhc_state_s st;
	tdhc_state_s next_st;
	logic [7:0] tdhc_mem [TDHC_MEM_WORDS];
	tdhc_crc_s crc_q;
	tdhc_crc_s crc_next;
	logic [13:0] idx_w;
	logic word_ok;
	logic is_buf;
	logic [7:0] buf_addr;
	logic setup;
	logic commit;
	logic wr_commit;
	logic next_free;
	logic [7:0] tx_byte;
	logic crc_init;
	logic crc_en;
	logic eot_evt;
	logic [6:0] reps_inc;

	assign idx_w = apb_req.paddr[15:2];
	assign word_ok = (apb_req.paddr[1:0] == 2'b00);
	assign is_buf = (idx_w[13:8] == TDHC_IDX_BUF0_PAGE || idx_w[13:8] == TDHC_IDX_BUF1_PAGE)
		&& !idx_w[7];
	assign buf_addr = {idx_w[8], idx_w[6:0]};
	assign setup = apb_req.psel && apb_req.penable && !st.ack;
	assign commit = apb_req.psel && apb_req.penable && st.ack;
	assign wr_commit = commit && apb_req.pwrite && !st.slverr;
	// a buffer still being read in forces the pointer to the other one
	assign next_free = st.busy[0] ? 1'b1 : 1'b0;
	assign tx_byte = tdhc_mem[{st.cur_buf, st.idx}];
	assign reps_inc = st.reps + 7'd1;
	// crc controls sit outside the state process so that it never reads its own outputs
	assign crc_en = dl_bit_req && st.ones != TDHC_STUFF_RUN && st.tx == TX_DATA;
	assign crc_init = dl_bit_req && st.ones != TDHC_STUFF_RUN && st.bitcnt == 3'd7
		&& st.tx == TX_IDLE && st.pend && st.message_oriented_signaling && st.count != 7'd0;

	tdhc_crc16 u_crc (
		.pclk(pclk),
		.presetn(presetn),
		.init(crc_init),
		.en(crc_en),
		.din(st.sh[0]),
		.crc_q(crc_q),
		.crc_next(crc_next)
	);

	// buffer memory has no reset; software fills it before arming a start
	always_ff @(posedge pclk)
	begin
		if (wr_commit && is_buf)
			tdhc_mem[buf_addr] <= apb_req.pwdata[7:0];
	end

	always_comb
	begin
		next_st = st;
		eot_evt = 1'b0;
		// apb: one wait state, read data captured into a flop
		next_st.ack = setup;
		if (setup)
		begin
			next_st.slverr = !word_ok || !(is_buf || idx_w == TDHC_IDX_CTRL
				|| idx_w == TDHC_IDX_COUNT || idx_w == TDHC_IDX_IRQ_STAT
				|| idx_w == TDHC_IDX_IRQ_MASK);
			next_st.rdata = 32'h0000_0000;
			if (word_ok && is_buf)
				next_st.rdata = {24'h00_0000, tdhc_mem[buf_addr]};
			else if (word_ok && idx_w == TDHC_IDX_CTRL)
			begin
				next_st.rdata[TDHC_CTRL_FCS_BIT] = st.fcs_en;
				next_st.rdata[TDHC_CTRL_MOS_BIT] = st.message_oriented_signaling;
			end
			else if (word_ok && idx_w == TDHC_IDX_COUNT)
			begin
				next_st.rdata[TDHC_CNT_SEL_BIT] = next_free;
				next_st.rdata[6:0] = st.count;
			end
			else if (word_ok && idx_w == TDHC_IDX_IRQ_STAT)
				next_st.rdata[TDHC_IRQ_EOT_BIT] = st.irq_stat;
			else if (word_ok && idx_w == TDHC_IDX_IRQ_MASK)
				next_st.rdata[TDHC_IRQ_EOT_BIT] = st.irq_mask;
		end
		if (wr_commit)
		begin
			if (idx_w == TDHC_IDX_CTRL)
			begin
				next_st.fcs_en = apb_req.pwdata[TDHC_CTRL_FCS_BIT];
				next_st.message_oriented_signaling = apb_req.pwdata[TDHC_CTRL_MOS_BIT];
			end
			else if (idx_w == TDHC_IDX_COUNT)
			begin
				next_st.sel = apb_req.pwdata[TDHC_CNT_SEL_BIT];
				next_st.count = apb_req.pwdata[6:0];
				next_st.pend = 1'b1;
			end
			else if (idx_w == TDHC_IDX_IRQ_STAT && apb_req.pwdata[TDHC_IRQ_EOT_BIT])
				next_st.irq_stat = 1'b0;
			else if (idx_w == TDHC_IDX_IRQ_MASK)
				next_st.irq_mask = apb_req.pwdata[TDHC_IRQ_EOT_BIT];
		end
		// serializer, one bit per request from the framer
		if (dl_bit_req)
		begin
			if (st.ones == TDHC_STUFF_RUN)
			begin
				next_st.dl_bit = 1'b0;
				next_st.ones = 3'd0;
			end
			else
			begin
				next_st.dl_bit = st.sh[0];
				next_st.ones = (st.stuff && st.sh[0]) ? st.ones + 3'd1 : 3'd0;
				next_st.sh = {1'b0, st.sh[7:1]};
				next_st.bitcnt = st.bitcnt + 3'd1;
				if (st.bitcnt == 3'd7)
				begin
					next_st.sh = TDHC_FLAG;
					next_st.stuff = 1'b0;
					case (st.tx)
						TX_IDLE:
						begin
							if (st.pend)
							begin
								next_st.pend = 1'b0;
								next_st.cur_buf = st.sel;
								next_st.cur_mos = st.message_oriented_signaling;
								next_st.cur_fcs = st.fcs_en && st.message_oriented_signaling;
								next_st.cur_len = st.count;
								next_st.reps = 7'd0;
								next_st.idx = 7'd1;
								if (!st.message_oriented_signaling)
								begin
									next_st.tx = TX_BOS;
									next_st.busy[st.sel] = 1'b1;
									next_st.sh = tdhc_mem[{st.sel, 7'd0}];
								end
								else if (st.count == 7'd0)
									eot_evt = 1'b1;
								else
								begin
									next_st.tx = TX_DATA;
									next_st.busy[st.sel] = 1'b1;
									next_st.sh = tdhc_mem[{st.sel, 7'd0}];
									next_st.stuff = 1'b1;
								end
							end
						end
						TX_DATA:
						begin
							// length counts message octets only; fcs follows it
							if (st.idx == st.cur_len)
							begin
								next_st.busy[st.cur_buf] = 1'b0;
								if (st.cur_fcs)
								begin
									next_st.tx = TX_FCS;
									next_st.sh = ~crc_next.crc[7:0];
									next_st.stuff = 1'b1;
									next_st.idx = 7'd0;
								end
								else
								begin
									next_st.tx = TX_IDLE;
									eot_evt = 1'b1;
								end
							end
							else
							begin
								next_st.sh = tx_byte;
								next_st.stuff = 1'b1;
								next_st.idx = st.idx + 7'd1;
							end
						end
						TX_FCS:
						begin
							if (st.idx == 7'd0)
							begin
								next_st.sh = ~crc_q.crc[15:8];
								next_st.stuff = 1'b1;
								next_st.idx = 7'd1;
							end
							else
							begin
								next_st.tx = TX_IDLE;
								eot_evt = 1'b1;
							end
						end
						TX_BOS:
						begin
							// two-octet code word, repeated; count of zero repeats until a new start
							if (st.idx == 7'd1)
							begin
								next_st.sh = tx_byte;
								next_st.idx = 7'd0;
							end
							else
							begin
								next_st.reps = reps_inc;
								if (st.cur_len != 7'd0 && reps_inc == st.cur_len)
								begin
									next_st.tx = TX_IDLE;
									next_st.busy[st.cur_buf] = 1'b0;
									eot_evt = 1'b1;
								end
								else if (st.pend)
								begin
									next_st.tx = TX_IDLE;
									next_st.busy[st.cur_buf] = 1'b0;
								end
								else
								begin
									next_st.sh = tdhc_mem[{st.cur_buf, 7'd0}];
									next_st.idx = 7'd1;
								end
							end
						end
						default:
							next_st.tx = TX_IDLE;
					endcase
				end
			end
		end
		// a new event wins over a clear in the same cycle
		if (eot_evt)
			next_st.irq_stat = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= '0;
			st.sh <= TDHC_FLAG;
			st.tx <= TX_IDLE;
		end
		else
			st <= next_st;
	end

	assign apb_rsp.pready = st.ack;
	assign apb_rsp.prdata = st.rdata;
	assign apb_rsp.pslverr = st.slverr;
	assign dl_bit = st.dl_bit;
	assign tx_end_of_transfer_irq = st.irq_stat && st.irq_mask;

	// checks
	reset_zero_a: assert property (@(posedge pclk) $rose(presetn) |->
		st.fcs_en == 1'b0 && st.message_oriented_signaling == 1'b0 && st.sel == 1'b0 && st.count == 7'd0)
		else $error("control fields not zero after reset");
	apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
		apb_req.psel && apb_req.penable && !st.ack |=> apb_rsp.pready)
		else $error("apb access not answered after one wait state");
	stuff_run_a: assert property (@(posedge pclk) disable iff (!presetn)
		st.ones <= TDHC_STUFF_RUN)
		else $error("more than five ones without a stuffed zero");
	stuff_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		dl_bit_req && st.ones == TDHC_STUFF_RUN |=> dl_bit == 1'b0)
		else $error("stuffed zero missing");
	bos_no_fcs_a: assert property (@(posedge pclk) disable iff (!presetn)
		st.tx == TX_BOS |-> !st.cur_fcs)
		else $error("fcs active in bit-oriented mode");
	fcs_only_enabled_a: assert property (@(posedge pclk) disable iff (!presetn)
		st.tx == TX_FCS |-> st.cur_fcs && st.cur_mos)
		else $error("fcs sent without enable");
	idle_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		st.tx == TX_IDLE && st.bitcnt == 3'd0 && !st.stuff |-> st.sh == TDHC_FLAG)
		else $error("idle channel not loaded with flag");
	select_free_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup && !apb_req.pwrite && word_ok && idx_w == TDHC_IDX_COUNT && st.busy[st.cur_buf]
		|=> apb_rsp.prdata[TDHC_CNT_SEL_BIT] == !$past(st.cur_buf))
		else $error("select points at busy buffer");
	eot_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
		eot_evt |=> st.irq_stat && (!st.irq_mask || tx_end_of_transfer_irq))
		else $error("end of transfer not flagged");
	infinite_bos_a: assert property (@(posedge pclk) disable iff (!presetn)
		st.tx == TX_BOS && st.cur_len == 7'd0 && !st.pend |=> st.tx == TX_BOS)
		else $error("endless bit-oriented message halted");
	mos_len_a: assert property (@(posedge pclk) disable iff (!presetn)
		st.tx == TX_DATA |-> st.idx <= st.cur_len)
		else $error("message pointer beyond length");
	cov_mos_fcs_c: cover property (@(posedge pclk) disable iff (!presetn)
		st.tx == TX_FCS ##1 st.tx == TX_IDLE);
	cov_bos_done_c: cover property (@(posedge pclk) disable iff (!presetn)
		st.tx == TX_BOS && eot_evt);
	cov_stuff_c: cover property (@(posedge pclk) disable iff (!presetn)
		dl_bit_req && st.ones == TDHC_STUFF_RUN);
	cov_irq_c: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(tx_end_of_transfer_irq));
endmodule : tdhc_top

// file: tdhc_link_model.sv
// far-side framer model: paces data-link bit requests and hands each bit to the bench
`timescale 1ns/1ps
module tdhc_link_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] gap,
	input wire logic dl_bit,
	output logic dl_bit_req,
	output logic got,
	output logic val
);
	logic [3:0] wait_cnt;
	logic req_q;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wait_cnt <= 4'h0;
			dl_bit_req <= 1'b0;
			req_q <= 1'b0;
			got <= 1'b0;
			val <= 1'b0;
		end
		else
		begin
			req_q <= dl_bit_req;
			got <= req_q;
			val <= dl_bit;
			// gap 0 asks every cycle, larger gaps stall the serializer
			dl_bit_req <= (wait_cnt == 4'h0);
			wait_cnt <= (wait_cnt == 4'h0) ? gap : wait_cnt - 4'h1;
		end
	end
endmodule : tdhc_link_model

// file: tx_datalink_hdlc_control_test.sv
// self-checking bench: apb register traffic and decoding of the data-link stream
`timescale 1ns/1ps
module tx_datalink_hdlc_control_test;
	import tdhc_pkg::*;
	localparam logic [15:0] A_CTRL = {TDHC_IDX_CTRL, 2'b00};
	localparam logic [15:0] A_CNT = {TDHC_IDX_COUNT, 2'b00};
	localparam logic [15:0] A_STAT = {TDHC_IDX_IRQ_STAT, 2'b00};
	localparam logic [15:0] A_MASK = {TDHC_IDX_IRQ_MASK, 2'b00};
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	tdhc_apb_req_s apb_req = '0;
	tdhc_apb_rsp_s apb_rsp;
	logic dl_bit_req, dl_bit, irq, got, val, e;
	logic [3:0] gap = 4'h0;
	logic [31:0] r;
	logic [31:0] seed = 32'h1b1b;
	logic bits[$];
	logic [7:0] fr[$];
	logic [7:0] msg[5];
	int fail_count = 0;
	int checks = 0;
	int p = 0;
	always #2.5 pclk = ~pclk;
	tdhc_top dut_u (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
		.dl_bit_req(dl_bit_req), .dl_bit(dl_bit), .tx_end_of_transfer_irq(irq));
	tdhc_link_model link_u (.pclk(pclk), .presetn(presetn), .gap(gap), .dl_bit(dl_bit),
		.dl_bit_req(dl_bit_req), .got(got), .val(val));
	always @(posedge pclk) if (got === 1'b1) bits.push_back(val);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic we, input logic [15:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: we, paddr: a, pwdata: d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req <= '0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic y;
		apb(1'b1, a, d, x, y);
	endtask : wr
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd
	function automatic logic [15:0] bufa(logic b, int i);
		return {b ? TDHC_IDX_BUF1_PAGE : TDHC_IDX_BUF0_PAGE, 8'(i), 2'b00};
	endfunction : bufa
	function automatic logic [7:0] oct(int q);
		logic [7:0] o;
		for (int i = 0; i < 8; i++)
			o[i] = bits[q + i];
		return o;
	endfunction : oct
	function automatic logic [15:0] fcs(int n);
		logic [15:0] c;
		c = TDHC_CRC_INIT;
		for (int i = 0; i < n * 8; i++)
			c = (c >> 1) ^ (((c[0] ^ msg[i / 8][i % 8]) == 1'b1) ? TDHC_CRC_POLY : 16'h0000);
		return ~c;
	endfunction : fcs
	task automatic wait_bits(int n);
		int s;
		s = bits.size();
		while (bits.size() < s + n)
			@(posedge pclk);
	endtask : wait_bits
	task automatic skip_flags();
		while (oct(p) === TDHC_FLAG)
			p += 8;
	endtask : skip_flags
	task automatic get_frame();
		logic c[$];
		logic [7:0] b;
		int ones;
		ones = 0;
		skip_flags();
		while (ones < 6 && p < bits.size())
		begin
			// a zero after five ones is stuffing, six ones is the closing flag
			if (ones == 5 && bits[p] === 1'b0)
				ones = 0;
			else
			begin
				ones = (bits[p] === 1'b1) ? ones + 1 : 0;
				c.push_back(bits[p]);
			end
			p++;
		end
		p++;
		fr = {};
		for (int i = 0; i < (c.size() - 7) / 8; i++)
		begin
			for (int j = 0; j < 8; j++)
				b[j] = c[i * 8 + j];
			fr.push_back(b);
		end
	endtask : get_frame
	task automatic wrap_up();
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	initial
	begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		wrap_up();
	end
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, A_CTRL, '0, r, e);
		chk(r, 32'h0);
		apb(1'b0, A_CNT, '0, r, e);
		chk(r, 32'h0);
		apb(1'b0, 16'h0000, '0, r, e);
		chk(e, 1'b1);
		apb(1'b0, A_CTRL + 16'h1, '0, r, e);
		chk(e, 1'b1);
		chk(irq, 1'b0);
		wait_bits(24);
		for (int i = 0; i < 3; i++)
			chk(oct(8 * i), TDHC_FLAG);
		$display("test reset and idle done");
		for (int k = 0; k < 2; k++)
		begin
			gap <= k ? 4'h3 : 4'h0;
			for (int i = 0; i < 5; i++)
			begin
				// an all-ones octet forces zero insertion
				msg[i] = (i == 0) ? 8'hff : rnd();
				wr(bufa(!k[0], i), {24'h0, msg[i]});
			end
			wr(A_MASK, k);
			wr(A_CTRL, {30'h0, k[0], 1'b1});
			apb(1'b0, A_CTRL, '0, r, e);
			chk(r, {30'h0, k[0], 1'b1});
			wr(A_CNT, {24'h0, !k[0], 7'd5});
			wait_bits(20);
			apb(1'b0, A_CNT, '0, r, e);
			chk(r, {24'h0, k[0], 7'd5});
			wait_bits(100);
			apb(1'b0, A_STAT, '0, r, e);
			chk(r, 32'h1);
			chk(irq, k[0]);
			wr(A_STAT, 32'h1);
			chk(irq, 1'b0);
			get_frame();
			chk(fr.size(), 5 + 2 * k);
			for (int i = 0; i < 5; i++)
				chk(fr[i], msg[i]);
			if (k == 1)
				chk({fr[6], fr[5]}, fcs(5));
			$display("test message frame %0d done", k);
		end
		gap <= 4'h1;
		for (int i = 0; i < 2; i++)
		begin
			msg[i] = rnd() | 8'h01;
			wr(bufa(1'b1, i), {24'h0, msg[i]});
		end
		wr(A_CTRL, 32'h2);
		wr(A_CNT, 32'h82);
		wait_bits(60);
		skip_flags();
		for (int i = 0; i < 4; i++)
			chk(oct(p + 8 * i), msg[i % 2]);
		chk(oct(p + 32), TDHC_FLAG);
		apb(1'b0, A_STAT, '0, r, e);
		chk(r, 32'h1);
		wr(A_STAT, 32'h1);
		p += 32;
		$display("test counted bit-oriented done");
		for (int i = 0; i < 2; i++)
		begin
			msg[i] = rnd() | 8'h01;
			wr(bufa(1'b0, i), {24'h0, msg[i]});
		end
		wr(A_CTRL, 32'h0);
		wr(A_CNT, 32'h0);
		wait_bits(120);
		skip_flags();
		for (int i = 0; i < 10; i++)
			chk(oct(p + 8 * i), msg[i % 2]);
		apb(1'b0, A_STAT, '0, r, e);
		chk(r, 32'h0);
		apb(1'b0, A_CNT, '0, r, e);
		chk(r, 32'h80);
		$display("test endless bit-oriented done");
		// a new start ends the endless code word; an empty message ends at once
		wr(A_CTRL, 32'h1);
		wr(A_CNT, 32'h0);
		wait_bits(40);
		apb(1'b0, A_STAT, '0, r, e);
		chk(r, 32'h1);
		chk(irq, 1'b1);
		$display("test empty message done");
		wrap_up();
	end
endmodule : tx_datalink_hdlc_control_test
